// ===== hw/frpd_cmd.sv
// command decoder for software reset, mode-bit clear, deep sleep and wake/id
// What this block does
// - any other command disarms the reset arm
// - software reset follows an armed reset-arm
// - mode-bit clear leaves continuous read mode
// - deep sleep only if select rises after bit eight
// - sleep entered within the sleep entry delay
// - asleep, only wake-and-id is recognised
// - hardware reset from sleep restores normal operation
// - power-up always lands in normal operation
// - wake needs select high for wake delay
// - id read: opcode, three dummies, msb first
// - clocking past the id gives undefined data
// - wake-and-id ignored while device busy
// - four-line mode: opcodes and id on four lines
// - param read uses a separate address space
// - param space is read-only
// - header at zero, parameters at 0300h
// - software reset reloads defaults, keeps lock bits
// - software reset starts at select rise, takes recovery
`timescale 1ns/1ps
`default_nettype none
module frpd_cmd
   import frpd_pkg::*;
#(
   parameter int RESET_RECOVERY_CYC = FRPD_RESET_RECOVERY_CYC,
   parameter logic [7:0] DEVICE_ID = FRPD_DEVICE_ID
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic [3:0] quad_data_lines_i,
   output logic [3:0] quad_data_lines_o,
   output logic [3:0] quad_data_lines_oe_o,
   input wire logic four_line_instruction_mode_i,
   input wire logic busy_i,
   input wire logic xip_enter_i,
   input wire logic protection_lock_bit_i,
   input wire logic status_protect_bit_i,
   output logic protection_lock_bit_o,
   output logic status_protect_bit_o,
   output logic reload_defaults_o,
   output logic deep_sleep_o,
   output logic ready_o,
   output logic xip_active_o
);
   frpd_pins_t pins_raw;
   frpd_pins_t pins;
   logic sck_rise;
   logic sck_fall;
   logic [7:0] rom_data;

   frpd_state_t st_q, st_d;
   frpd_power_t pw_q, pw_d;
   logic [7:0] shift_q, shift_d;
   logic [3:0] cnt_q, cnt_d;
   logic [3:0] byte_q, byte_d;
   logic [FRPD_PARAM_AW-1:0] addr_q, addr_d;
   logic [7:0] out_q, out_d;
   logic [3:0] dq_q, dq_d;
   logic [3:0] oe_q, oe_d;
   logic armed_q, armed_d;
   logic op_done_q, op_done_d;
   logic [7:0] op_q, op_d;
   logic xip_q, xip_d;
   logic [FRPD_TIMER_W-1:0] tmr_q, tmr_d;
   logic lock_q, lock_d;
   logic srp_q, srp_d;
   logic reload_q, reload_d;
   logic cs_prev_q, cs_prev_d;
   logic cs_rise;
   logic quad;
   logic [7:0] shift_next;
   logic [3:0] unit_bits;
   logic extra_clk;

   assign pins_raw = '{cs_n: cs_n_i, sck: sck_i, dq: quad_data_lines_i};

   frpd_pin_sync u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .pins_i(pins_raw),
      .pins_o(pins),
      .sck_rise_o(sck_rise),
      .sck_fall_o(sck_fall)
   );

   frpd_param_rom u_rom (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .addr_i(addr_q),
      .data_o(rom_data)
   );

   // clock count of one byte at the current width: eight bits or two nibbles
   function automatic logic [3:0] units_per_byte(input logic q);
      units_per_byte = q ? FRPD_BYTE_NIBBLES : FRPD_BYTE_BITS;
   endfunction

   function automatic logic [7:0] shift_in(input logic q, input logic [7:0] s,
                                           input logic [3:0] d);
      shift_in = q ? {s[3:0], d} : {s[6:0], d[0]};
   endfunction

   assign quad = four_line_instruction_mode_i;
   assign cs_rise = pins.cs_n & ~cs_prev_q;
   assign unit_bits = units_per_byte(quad);
   // the frame saw clocks after its opcode was complete
   assign extra_clk = (st_q == FRPD_ST_IGNORE) && (cnt_q != '0);
   // rising-edge sampling, one or four bits per clock
   assign shift_next = shift_in(quad, shift_q, pins.dq);

   always_comb begin
      st_d = st_q;
      pw_d = pw_q;
      shift_d = shift_q;
      cnt_d = cnt_q;
      byte_d = byte_q;
      addr_d = addr_q;
      out_d = out_q;
      dq_d = dq_q;
      oe_d = oe_q;
      armed_d = armed_q;
      op_done_d = op_done_q;
      op_d = op_q;
      xip_d = xip_q;
      tmr_d = tmr_q;
      lock_d = lock_q;
      srp_d = srp_q;
      reload_d = 1'b0;
      cs_prev_d = pins.cs_n;

      if (tmr_q != '0) begin
         tmr_d = tmr_q - 1'b1;
      end

      case (pw_q)
         FRPD_PW_ENTERING: begin
            // sleep state reached within the entry delay
            if (tmr_q == '0) begin
               pw_d = FRPD_PW_ASLEEP;
            end
         end
         FRPD_PW_WAKING, FRPD_PW_RESETTING: begin
            if (tmr_q == '0) begin
               pw_d = FRPD_PW_NORMAL;
            end
         end
         default: begin
         end
      endcase

      if (pins.cs_n) begin
         st_d = xip_q ? FRPD_ST_XIP : FRPD_ST_OPCODE;
         cnt_d = '0;
         byte_d = '0;
         oe_d = 4'h0;
         if (cs_rise && op_done_q) begin
            // a completed opcode acts only once select rises
            if (op_q == FRPD_OP_DEEP_SLEEP && pw_q == FRPD_PW_NORMAL && !extra_clk) begin
               pw_d = FRPD_PW_ENTERING;
               tmr_d = FRPD_TIMER_W'(FRPD_SLEEP_ENTRY_CYC);
            end else if (op_q == FRPD_OP_WAKE_AND_ID && pw_q == FRPD_PW_ASLEEP) begin
               // wake, then refuse commands for the wake delay
               pw_d = FRPD_PW_WAKING;
               tmr_d = FRPD_TIMER_W'(FRPD_WAKE_CYC);
            end else if (op_q == FRPD_OP_SW_RESET && armed_q && !extra_clk) begin
               // reset begins at select rise, lasts recovery time
               pw_d = FRPD_PW_RESETTING;
               tmr_d = FRPD_TIMER_W'(RESET_RECOVERY_CYC);
               reload_d = 1'b1;
               armed_d = 1'b0;
               xip_d = 1'b0;
            end
            // the arm survives only the command right after it
            if (op_q == FRPD_OP_RESET_ARM && pw_q == FRPD_PW_NORMAL && !extra_clk) begin
               armed_d = 1'b1;
            end else begin
               armed_d = 1'b0;
            end
         end
         if (cs_rise) begin
            op_done_d = 1'b0;
         end
      end else if (sck_rise) begin
         case (st_q)
            FRPD_ST_OPCODE: begin
               shift_d = shift_next;
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == unit_bits - 1'b1) begin
                  op_d = shift_next;
                  op_done_d = 1'b1;
                  cnt_d = '0;
                  st_d = FRPD_ST_IGNORE;
                  if (pw_q == FRPD_PW_ASLEEP) begin
                     // only wake-and-id is heard while asleep
                     if (shift_next != FRPD_OP_WAKE_AND_ID || busy_i) begin
                        op_done_d = 1'b0;
                     end
                  end else if (pw_q != FRPD_PW_NORMAL) begin
                     op_done_d = 1'b0;
                  end else if (shift_next == FRPD_OP_WAKE_AND_ID) begin
                     // ignored during erase, program or write
                     if (busy_i) begin
                        op_done_d = 1'b0;
                     end else begin
                        st_d = FRPD_ST_ID_DUMMY;
                     end
                  end else if (shift_next == FRPD_OP_PARAM_READ) begin
                     st_d = FRPD_ST_P_ADDR;
                     addr_d = '0;
                  end
               end
            end
            FRPD_ST_IGNORE: begin
               // clocks past the opcode: select did not rise after bit eight
               cnt_d = unit_bits;
            end
            FRPD_ST_XIP: begin
               // mode-bit clear: only line zero counts, all ones
               cnt_d = cnt_q + 1'b1;
               if (!pins.dq[0]) begin
                  st_d = FRPD_ST_IGNORE;
               end else if (cnt_q == FRPD_OPCODE_BITS - 1'b1) begin
                  xip_d = 1'b0;
                  st_d = FRPD_ST_IGNORE;
               end
            end
            FRPD_ST_ID_DUMMY, FRPD_ST_P_ADDR, FRPD_ST_P_DUMMY: begin
               shift_d = shift_next;
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == unit_bits - 1'b1) begin
                  cnt_d = '0;
                  byte_d = byte_q + 1'b1;
                  if (st_q == FRPD_ST_P_ADDR) begin
                     addr_d = FRPD_PARAM_AW'({addr_q, shift_next});
                  end
                  if (st_q == FRPD_ST_ID_DUMMY && byte_q == FRPD_DUMMY_BYTES - 1'b1) begin
                     st_d = FRPD_ST_ID_OUT;
                     out_d = DEVICE_ID;
                  end else if (st_q == FRPD_ST_P_ADDR && byte_q == FRPD_ADDR_BYTES - 1'b1) begin
                     st_d = FRPD_ST_P_DUMMY;
                     byte_d = '0;
                  end else if (st_q == FRPD_ST_P_DUMMY &&
                               byte_q == FRPD_PARAM_DUMMY_BYTES - 1'b1) begin
                     st_d = FRPD_ST_P_OUT;
                     out_d = rom_data;
                     addr_d = addr_q + 1'b1;
                  end
               end
            end
            default: begin
            end
         endcase
      end else if (sck_fall) begin
         // shift out on falling edges, msb first
         if (st_q == FRPD_ST_ID_OUT || st_q == FRPD_ST_P_OUT) begin
            oe_d = quad ? 4'hf : 4'h2;
            dq_d = quad ? out_q[7:4] : {2'b00, out_q[7], 1'b0};
            out_d = quad ? {out_q[3:0], 4'h0} : {out_q[6:0], 1'b0};
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == unit_bits - 1'b1) begin
               cnt_d = '0;
               if (st_q == FRPD_ST_P_OUT) begin
                  out_d = rom_data;
                  addr_d = addr_q + 1'b1;
               end else begin
                  // past the id the data is undefined; zeros are sent
                  out_d = 8'h00;
               end
            end
         end
      end

      // entering continuous read wins over a clear in the same cycle
      if (xip_enter_i) begin
         xip_d = 1'b1;
      end

      // lock bits keep their value across a software reset
      if (pw_q != FRPD_PW_RESETTING) begin
         lock_d = protection_lock_bit_i;
         srp_d = status_protect_bit_i;
      end
   end

   // async reset is the power-on path: always normal, never asleep
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= FRPD_ST_OPCODE;
         pw_q <= FRPD_PW_NORMAL;
         shift_q <= 8'h00;
         cnt_q <= 4'h0;
         byte_q <= 4'h0;
         addr_q <= '0;
         out_q <= 8'h00;
         dq_q <= 4'h0;
         oe_q <= 4'h0;
         armed_q <= 1'b0;
         op_done_q <= 1'b0;
         op_q <= 8'h00;
         xip_q <= 1'b0;
         tmr_q <= '0;
         lock_q <= 1'b0;
         srp_q <= 1'b0;
         reload_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else if (clk_en_i) begin
         st_q <= st_d;
         pw_q <= pw_d;
         shift_q <= shift_d;
         cnt_q <= cnt_d;
         byte_q <= byte_d;
         addr_q <= addr_d;
         out_q <= out_d;
         dq_q <= dq_d;
         oe_q <= oe_d;
         armed_q <= armed_d;
         op_done_q <= op_done_d;
         op_q <= op_d;
         xip_q <= xip_d;
         tmr_q <= tmr_d;
         lock_q <= lock_d;
         srp_q <= srp_d;
         reload_q <= reload_d;
         cs_prev_q <= cs_prev_d;
      end
   end

   assign quad_data_lines_o = dq_q;
   assign quad_data_lines_oe_o = oe_q;
   assign protection_lock_bit_o = lock_q;
   assign status_protect_bit_o = srp_q;
   assign reload_defaults_o = reload_q;
   assign deep_sleep_o = (pw_q == FRPD_PW_ASLEEP);
   assign ready_o = (pw_q == FRPD_PW_NORMAL);
   assign xip_active_o = xip_q;
endmodule
`default_nettype wire

// ===== hw/frpd_param_rom.sv
// read-only discoverable-parameter space with a registered read port
`timescale 1ns/1ps
`default_nettype none
module frpd_param_rom
   import frpd_pkg::*;
#(
   parameter int AW = FRPD_PARAM_AW
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic [AW-1:0] addr_i,
   output logic [7:0] data_o
);
   logic [7:0] data_d;
   logic [7:0] data_q;

   // no write port exists: the space cannot be altered
   always_comb begin
      data_d = FRPD_UNDEF_BYTE;
      // header at location zero, parameters from 0300h, gaps undefined
      case (addr_i)
         FRPD_PARAM_HDR_BASE + 10'h000: data_d = 8'h53;
         FRPD_PARAM_HDR_BASE + 10'h001: data_d = 8'h46;
         FRPD_PARAM_HDR_BASE + 10'h002: data_d = 8'h44;
         FRPD_PARAM_HDR_BASE + 10'h003: data_d = 8'h50;
         FRPD_PARAM_HDR_BASE + 10'h004: data_d = 8'h06;
         FRPD_PARAM_HDR_BASE + 10'h005: data_d = 8'h01;
         FRPD_PARAM_HDR_BASE + 10'h006: data_d = 8'h01;
         FRPD_PARAM_DATA_BASE: data_d = 8'h00;
         default: data_d = FRPD_UNDEF_BYTE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_q <= 8'h00;
      end else if (clk_en_i) begin
         data_q <= data_d;
      end
   end

   assign data_o = data_q;
endmodule
`default_nettype wire

// ===== hw/frpd_pin_sync.sv
// two-stage synchroniser for the serial pins, with clock edge detection
`timescale 1ns/1ps
`default_nettype none
module frpd_pin_sync
   import frpd_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire frpd_pins_t pins_i,
   output frpd_pins_t pins_o,
   output logic sck_rise_o,
   output logic sck_fall_o
);
   frpd_pins_t meta_q;
   frpd_pins_t sync_q;
   frpd_pins_t prev_q;
   frpd_pins_t meta_d;
   frpd_pins_t sync_d;
   frpd_pins_t prev_d;

   always_comb begin
      meta_d = pins_i;
      sync_d = meta_q;
      prev_d = sync_q;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '{cs_n: 1'b1, sck: 1'b0, dq: 4'h0};
         sync_q <= '{cs_n: 1'b1, sck: 1'b0, dq: 4'h0};
         prev_q <= '{cs_n: 1'b1, sck: 1'b0, dq: 4'h0};
      end else if (clk_en_i) begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   assign pins_o = sync_q;
   assign sck_rise_o = sync_q.sck & ~prev_q.sck & ~sync_q.cs_n;
   assign sck_fall_o = ~sync_q.sck & prev_q.sck & ~sync_q.cs_n;
endmodule
`default_nettype wire

// ===== hw/frpd_pkg.sv
// shared constants and types for the flash reset and power-down command block
package frpd_pkg;
   localparam logic [7:0] FRPD_OP_RESET_ARM = 8'h66;
   localparam logic [7:0] FRPD_OP_SW_RESET = 8'h99;
   localparam logic [7:0] FRPD_OP_MODE_BIT_CLEAR = 8'hff;
   localparam logic [7:0] FRPD_OP_DEEP_SLEEP = 8'hb9;
   localparam logic [7:0] FRPD_OP_WAKE_AND_ID = 8'hab;
   localparam logic [7:0] FRPD_OP_PARAM_READ = 8'h5a;
   localparam logic [3:0] FRPD_OPCODE_BITS = 4'h8;
   localparam logic [3:0] FRPD_OPCODE_NIBBLES = 4'h2;
   localparam logic [3:0] FRPD_ADDR_BYTES = 4'h3;
   localparam logic [3:0] FRPD_DUMMY_BYTES = 4'h3;
   localparam logic [3:0] FRPD_PARAM_DUMMY_BYTES = 4'h1;
   localparam logic [3:0] FRPD_BYTE_BITS = 4'h8;
   localparam logic [3:0] FRPD_BYTE_NIBBLES = 4'h2;
   localparam logic [3:0] FRPD_ID_BITS = 4'h8;
   localparam int FRPD_CLK_MHZ = 125;
   localparam int FRPD_SLEEP_ENTRY_NS = 3000;
   localparam int FRPD_WAKE_NS = 3000;
   localparam int FRPD_RESET_RECOVERY_NS = 35000;
   // longest times round down, none below one cycle
   localparam int FRPD_SLEEP_ENTRY_CYC = (FRPD_SLEEP_ENTRY_NS * FRPD_CLK_MHZ / 1000) < 1 ? 1 :
      (FRPD_SLEEP_ENTRY_NS * FRPD_CLK_MHZ / 1000);
   // least times round up
   localparam int FRPD_WAKE_CYC = (FRPD_WAKE_NS * FRPD_CLK_MHZ + 999) / 1000;
   localparam int FRPD_RESET_RECOVERY_CYC = (FRPD_RESET_RECOVERY_NS * FRPD_CLK_MHZ + 999) / 1000;
   localparam int FRPD_TIMER_W = 16;
   localparam int FRPD_PARAM_AW = 10;
   localparam logic [9:0] FRPD_PARAM_HDR_BASE = 10'h000;
   localparam logic [9:0] FRPD_PARAM_DATA_BASE = 10'h300;
   localparam logic [7:0] FRPD_UNDEF_BYTE = 8'hff;
   localparam logic [7:0] FRPD_DEVICE_ID = 8'h5c; // arbitrary value

   typedef enum logic [3:0] {
      FRPD_ST_OPCODE = 4'b0000,
      FRPD_ST_ID_DUMMY = 4'b0001,
      FRPD_ST_ID_OUT = 4'b0010,
      FRPD_ST_P_ADDR = 4'b0011,
      FRPD_ST_P_DUMMY = 4'b0100,
      FRPD_ST_P_OUT = 4'b0101,
      FRPD_ST_IGNORE = 4'b0110,
      FRPD_ST_XIP = 4'b0111
   } frpd_state_t;

   typedef enum logic [2:0] {
      FRPD_PW_NORMAL = 3'b000,
      FRPD_PW_ENTERING = 3'b001,
      FRPD_PW_ASLEEP = 3'b010,
      FRPD_PW_WAKING = 3'b011,
      FRPD_PW_RESETTING = 3'b100
   } frpd_power_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic [3:0] dq;
   } frpd_pins_t;

   typedef struct packed {
      logic [3:0] dq;
      logic [3:0] dq_oe;
   } frpd_drive_t;
endpackage

// ===== testbench/frpd_cmd_monitor.sv
// assertion checker for the reset and power-down command decoder
`timescale 1ns/1ps
`default_nettype none
module frpd_cmd_monitor
   import frpd_pkg::*;
#(
   parameter int RESET_RECOVERY_CYC = FRPD_RESET_RECOVERY_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic cs_n_i,
   input wire logic [3:0] quad_data_lines_oe_o,
   input wire logic protection_lock_bit_o,
   input wire logic status_protect_bit_o,
   input wire logic reload_defaults_o,
   input wire logic deep_sleep_o,
   input wire logic ready_o,
   input wire logic xip_active_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // cycles since the select pin last went high, saturating
   logic [15:0] since_cs_q;
   logic [15:0] since_cs_d;
   always_comb begin
      since_cs_d = since_cs_q;
      if (cs_n_i == 1'b0) since_cs_d = 16'h0000;
      else if (since_cs_q != 16'hffff) since_cs_d = since_cs_q + 16'h0001;
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) since_cs_q <= 16'hffff;
      else since_cs_q <= since_cs_d;
   end
   AST_POWERUP_NORMAL: assert property (
      $rose(rst_n_i) |-> ready_o && !deep_sleep_o && !xip_active_o)
      else $error("not in normal operation after reset");
   AST_RELOAD_PULSE: assert property (reload_defaults_o |=> !reload_defaults_o)
      else $error("reload pulse longer than one cycle");
   AST_RELOAD_AT_CS_HIGH: assert property (
      reload_defaults_o |-> cs_n_i && $past(cs_n_i, 2))
      else $error("reload while select low");
   AST_LOCK_HELD: assert property (
      reload_defaults_o |-> $stable(protection_lock_bit_o) && $stable(status_protect_bit_o))
      else $error("lock bits changed by reload");
   AST_XIP_EXIT_IN_FRAME: assert property ($fell(xip_active_o) |-> !cs_n_i)
      else $error("continuous read left outside a frame");
   AST_SLEEP_ENTRY_TIME: assert property ($rose(deep_sleep_o) |->
      since_cs_q >= 16'(FRPD_SLEEP_ENTRY_CYC) && since_cs_q <= 16'(FRPD_SLEEP_ENTRY_CYC + 10))
      else $error("sleep entry delay wrong");
   AST_READY_AFTER_DELAY: assert property (
      $rose(ready_o) |-> since_cs_q >= 16'(RESET_RECOVERY_CYC))
      else $error("ready returned too early");
   AST_OE_RELEASED: assert property (cs_n_i [*6] |-> quad_data_lines_oe_o == 4'h0)
      else $error("data lines driven with select high");
   cover property ($rose(deep_sleep_o));
   cover property ($fell(xip_active_o));
   cover property (reload_defaults_o);
endmodule
bind frpd_cmd frpd_cmd_monitor #(.RESET_RECOVERY_CYC(RESET_RECOVERY_CYC)) frpd_cmd_monitor_i (
   .ref_clk_i(ref_clk_i),
   .rst_n_i(rst_n_i),
   .cs_n_i(cs_n_i),
   .quad_data_lines_oe_o(quad_data_lines_oe_o),
   .protection_lock_bit_o(protection_lock_bit_o),
   .status_protect_bit_o(status_protect_bit_o),
   .reload_defaults_o(reload_defaults_o),
   .deep_sleep_o(deep_sleep_o),
   .ready_o(ready_o),
   .xip_active_o(xip_active_o)
);
`default_nettype wire

// ===== testbench/frpd_host_model.sv
// behavioural host controller that frames opcodes on the serial pins
`timescale 1ns/1ps
`default_nettype none
module frpd_host_model
   import frpd_pkg::*;
(
   input wire logic quad_i,
   input wire logic [3:0] dev_dq_i,
   input wire logic [3:0] dev_oe_i,
   output frpd_pins_t pins_o,
   output logic [3:0] dq_wire_o
);
   logic [3:0] host_oe;
   logic tog;
   initial begin
      pins_o = '{cs_n: 1'b1, sck: 1'b0, dq: 4'h0};
      host_oe = 4'h0;
      tog = 1'b0;
   end
   always #8 tog = ~tog;
   // a released line shows a changing pattern, never a held value
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         if (dev_oe_i[k]) dq_wire_o[k] = dev_dq_i[k];
         else if (host_oe[k]) dq_wire_o[k] = pins_o.dq[k];
         else dq_wire_o[k] = tog ^ k[0];
      end
   end
   // mode 0 frame: msb first, one bit or one nibble per clock, then reads
   task automatic frame(input logic [39:0] tx, input int n_bytes, input int rd_clk,
                        output logic [31:0] rx);
      int step;
      step = quad_i ? 4 : 1;
      rx = 32'h0;
      pins_o.cs_n = 1'b0;
      host_oe = quad_i ? 4'hf : 4'h1;
      for (int i = 8 * n_bytes - step; i >= 0; i -= step) begin
         pins_o.dq = quad_i ? tx[i +: 4] : {3'b000, tx[i]};
         #32 pins_o.sck = 1'b1;
         #32 pins_o.sck = 1'b0;
      end
      host_oe = 4'h0;
      for (int j = 0; j < rd_clk; j++) begin
         #32 pins_o.sck = 1'b1;
         rx = quad_i ? {rx[27:0], dq_wire_o} : {rx[30:0], dq_wire_o[1]};
         #32 pins_o.sck = 1'b0;
      end
      #32 pins_o.cs_n = 1'b1;
      #64;
   endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the reset and power-down command decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("unexpected %s expected %h seen %h", name, exp, got); end end
module tb_top;
   import frpd_pkg::*;
   logic ref_clk, rst_n, quad, busy, xip_enter, lock_in, sp_in;
   logic [3:0] dq_o, dq_oe, dq_wire;
   logic lock_out, sp_out, reload, sleep, ready, xip;
   logic [31:0] rx;
   frpd_pins_t pins;
   int n_mismatch, cmp_count, reload_cnt;
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (reload === 1'b1) reload_cnt++;
   frpd_host_model frpd_host_model_i (.quad_i(quad), .dev_dq_i(dq_o), .dev_oe_i(dq_oe),
      .pins_o(pins), .dq_wire_o(dq_wire));
   frpd_cmd #(.RESET_RECOVERY_CYC(20), .DEVICE_ID(8'h3a)) frpd_cmd_i (
      .ref_clk_i(ref_clk),
      .rst_n_i(rst_n),
      .clk_en_i(1'b1),
      .cs_n_i(pins.cs_n),
      .sck_i(pins.sck),
      .quad_data_lines_i(dq_wire),
      .quad_data_lines_o(dq_o),
      .quad_data_lines_oe_o(dq_oe),
      .four_line_instruction_mode_i(quad),
      .busy_i(busy),
      .xip_enter_i(xip_enter),
      .protection_lock_bit_i(lock_in),
      .status_protect_bit_i(sp_in),
      .protection_lock_bit_o(lock_out),
      .status_protect_bit_o(sp_out),
      .reload_defaults_o(reload),
      .deep_sleep_o(sleep),
      .ready_o(ready),
      .xip_active_o(xip)
   );
   task automatic results();
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // sel 0 watches deep sleep, 1 watches ready
   task automatic wait_for(input int sel, input logic lvl, input int lim);
      int c;
      c = 0;
      while (((sel == 0) ? sleep : ready) !== lvl && c < lim) begin
         @(negedge ref_clk);
         c++;
      end
      if (c >= lim) begin
         n_mismatch++;
         $display("unexpected wait %0d expected %b seen timeout", sel, lvl);
         results();
      end
   endtask
   task automatic send(input logic [39:0] tx, input int nb, input int rc);
      @(negedge ref_clk);
      frpd_host_model_i.frame(tx, nb, rc, rx);
   endtask
   task automatic t_powerup();
      `CHK("ready", 1'b1, ready)
      `CHK("sleep", 1'b0, sleep)
      `CHK("xip", 1'b0, xip)
      $display("test powerup done");
   endtask
   task automatic t_sw_reset();
      int base;
      base = reload_cnt;
      send(40'hff, 1, 0);
      send(40'h66, 1, 0);
      send(40'h05, 1, 0);
      send(40'h99, 1, 0);
      `CHK("reload after disarm", base, reload_cnt)
      quad = 1'b1;
      send(40'h66, 1, 0);
      send(40'h99, 1, 0);
      quad = 1'b0;
      `CHK("reload count", base + 1, reload_cnt)
      `CHK("ready in recovery", 1'b0, ready)
      lock_in = 1'b0;
      @(negedge ref_clk);
      `CHK("lock held in recovery", 1'b1, lock_out)
      lock_in = 1'b1;
      wait_for(1, 1'b1, 100);
      `CHK("lock kept", 1'b1, lock_out)
      `CHK("protect kept", 1'b1, sp_out)
      $display("test sw_reset done");
   endtask
   task automatic t_xip();
      @(negedge ref_clk);
      xip_enter = 1'b1;
      @(negedge ref_clk);
      xip_enter = 1'b0;
      @(negedge ref_clk);
      `CHK("xip set", 1'b1, xip)
      send(40'hff, 1, 0);
      `CHK("xip cleared", 1'b0, xip)
      $display("test xip done");
   endtask
   task automatic t_id();
      send({8'hab, 24'h0}, 4, 8);
      `CHK("id single", 8'h3a, rx[7:0])
      quad = 1'b1;
      send({8'hab, 24'h0}, 4, 2);
      quad = 1'b0;
      `CHK("id quad", 8'h3a, rx[7:0])
      $display("test id done");
   endtask
   task automatic t_param();
      send({8'h5a, 24'h000000, 8'h00}, 5, 16);
      `CHK("param header", 16'h5346, rx[15:0])
      send({8'h5a, 24'h000300, 8'h00}, 5, 8);
      `CHK("param data", 8'h00, rx[7:0])
      send({8'h5a, 24'h000010, 8'h00}, 5, 8);
      `CHK("param gap", 8'hff, rx[7:0])
      $display("test param done");
   endtask
   task automatic t_sleep();
      int base;
      send(40'hb9, 1, 1);
      repeat (450) @(negedge ref_clk);
      `CHK("sleep after extra clock", 1'b0, sleep)
      send(40'hb9, 1, 0);
      wait_for(0, 1'b1, 450);
      base = reload_cnt;
      send(40'h66, 1, 0);
      send(40'h99, 1, 0);
      `CHK("reset while asleep", base, reload_cnt)
      busy = 1'b1;
      send(40'hab, 1, 0);
      repeat (450) @(negedge ref_clk);
      busy = 1'b0;
      `CHK("wake while busy", 1'b1, sleep)
      send(40'hab, 1, 0);
      `CHK("ready during wake", 1'b0, ready)
      wait_for(1, 1'b1, 450);
      `CHK("awake", 1'b0, sleep)
      $display("test sleep done");
   endtask
   task automatic t_hw_reset();
      quad = 1'b1;
      send(40'hb9, 1, 0);
      quad = 1'b0;
      wait_for(0, 1'b1, 450);
      rst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      @(negedge ref_clk);
      `CHK("sleep after hw reset", 1'b0, sleep)
      `CHK("ready after hw reset", 1'b1, ready)
      $display("test hw_reset done");
   endtask
   initial begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      quad = 1'b0;
      busy = 1'b0;
      xip_enter = 1'b0;
      lock_in = 1'b1;
      sp_in = 1'b1;
      n_mismatch = 0;
      cmp_count = 0;
      reload_cnt = 0;
      repeat (8) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      t_powerup();
      t_sw_reset();
      t_xip();
      t_id();
      t_param();
      t_sleep();
      t_hw_reset();
      results();
   end
endmodule
`default_nettype wire
